// [hw/slm_pkg.sv]
// shared constants and types for the serial lane link monitor
package slm_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_TAG       = 8'h20;
	localparam logic [7:0] OFF_CONTROL   = 8'h30;
	localparam logic [7:0] OFF_STATUS    = 8'h34;
	localparam logic [7:0] OFF_MASK      = 8'h40;
	localparam logic [7:0] OFF_VALUE     = 8'h60;
	localparam logic [7:0] OFF_THRESHOLD = 8'h80;
	localparam logic [7:0] OFF_CAPTURE   = 8'h90;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int          CTL_TAG_CLEAR_BIT = 0;
	localparam int          STS_DONE_BIT      = 0;
	localparam int          STS_LANE_LSB      = 8;
	localparam int          STS_LANE_MSB      = 11;
	localparam int          STS_LAT_LSB       = 16;
	localparam int          STS_LAT_MSB       = 31;
	localparam int          NUM_LANES         = 4;
	localparam int          TAG_WIDTH         = 16;
	localparam int          LAT_WIDTH         = 16;
	localparam logic [31:0] RESET_WORD        = 32'h0000_0000;
	localparam logic [15:0] LAT_MAX           = 16'hffff;

	// link word as seen after the lane aligner
	typedef struct packed {
		logic        valid;  // 1 = data, 0 = idle
		logic [31:0] data;
	} slm_link_t;

	// per sync frame lane check report
	typedef struct packed {
		logic                 strobe; // one-cycle pulse at end of frame
		logic [NUM_LANES-1:0] pass;
	} slm_check_t;

	// latency counter states
	typedef enum logic [1:0] {
		LAT_IDLE  = 2'b00,
		LAT_COUNT = 2'b01,
		LAT_HOLD  = 2'b10
	} slm_lat_state_t;

endpackage

// [hw/slm_latency.sv]
// sync-to-first-trigger-word latency counter
`timescale 1ns/1ps

module slm_latency (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        sync_start,
	input  wire logic        trig_word,
	output logic [15:0]      latency
);

	slm_pkg::slm_lat_state_t state;
	logic [15:0]             count;

	// ------------------------------------------------------------
	// state sequence: a new sync restarts, first trigger word stops
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= slm_pkg::LAT_IDLE;
		end else if (sync_start) begin
			state <= slm_pkg::LAT_COUNT;
		end else begin
			unique case (state)
				slm_pkg::LAT_IDLE:  state <= slm_pkg::LAT_IDLE;
				slm_pkg::LAT_COUNT: state <= trig_word ? slm_pkg::LAT_HOLD : slm_pkg::LAT_COUNT;
				slm_pkg::LAT_HOLD:  state <= slm_pkg::LAT_HOLD;
				default:            state <= slm_pkg::LAT_IDLE;
			endcase
		end
	end

	// tick counter, saturates so a lost trigger never wraps to a small value
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			count <= 16'h0000;
		end else if (sync_start) begin
			count <= 16'h0000;
		end else if (state == slm_pkg::LAT_COUNT && count != slm_pkg::LAT_MAX) begin
			count <= count + 16'h0001;
		end
	end

	// published value changes only when a measurement completes
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			latency <= 16'h0000;
		end else if (state == slm_pkg::LAT_COUNT && trig_word && !sync_start) begin
			latency <= count;
		end
	end

endmodule

// [hw/slm_link_monitor.sv]
// per-transceiver link monitor: tag capture, lane checks, latency, registers
`timescale 1ns/1ps

module slm_link_monitor (
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	// register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [31:0]          reg_wdata,
	output logic [31:0]               reg_rdata,
	output logic                      reg_rvalid,
	// link side
	input  wire slm_pkg::slm_link_t   link_in,
	input  wire slm_pkg::slm_check_t  lane_check,
	input  wire logic                 sys_sync,
	input  wire logic                 trig_word,
	// debug capture engine
	input  wire logic                 capture_done,
	input  wire logic [31:0]          capture_word,
	output logic [31:0]               debug_match_mask,
	output logic [31:0]               debug_match_value,
	output logic [31:0]               debug_threshold,
	output logic                      capture_word_pop,
	output logic [15:0]               source_crate_tag
);

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	logic        write_control;
	logic        tag_clear;
	logic        link_valid_d;
	logic        sync_d;
	logic        sync_start;
	logic        link_start;
	logic [3:0]  lane_check_pass;
	logic        done_flag;
	logic [15:0] latency;
	logic [31:0] next_rdata;
	logic        write_mask;
	logic        write_value;
	logic        write_threshold;
	logic [31:0] status_value;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction

	assign write_control = reg_wr && hit(reg_addr, slm_pkg::OFF_CONTROL);
	// the control bit only ever lives for the write cycle, so it reads back zero
	assign tag_clear = write_control && reg_wdata[slm_pkg::CTL_TAG_CLEAR_BIT];

	// ------------------------------------------------------------
	// event edges
	// ------------------------------------------------------------
	// previous link valid, resets to the idle level so reset makes no false start
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			link_valid_d <= 1'b0;
		end else begin
			link_valid_d <= link_in.valid;
		end
	end

	// previous sync level, idle low after reset for the same reason
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sync_d <= 1'b0;
		end else begin
			sync_d <= sys_sync;
		end
	end

	assign link_start = link_in.valid && !link_valid_d;
	assign sync_start = sys_sync && !sync_d;

	// ------------------------------------------------------------
	// source crate tag
	// ------------------------------------------------------------
	// capture beats clear in the same cycle so a fresh tag is never lost
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			source_crate_tag <= 16'h0000;
		end else if (link_start) begin
			source_crate_tag <= link_in.data[slm_pkg::TAG_WIDTH-1:0];
		end else if (tag_clear) begin
			source_crate_tag <= 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// lane check and capture status
	// ------------------------------------------------------------
	// results replaced at the end of every sync frame
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lane_check_pass <= 4'h0;
		end else if (lane_check.strobe) begin
			lane_check_pass <= lane_check.pass;
		end
	end

	// done follows the capture engine level
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			done_flag <= 1'b0;
		end else begin
			done_flag <= capture_done;
		end
	end

	// ------------------------------------------------------------
	// latency measurement
	// ------------------------------------------------------------
	// sync edge starts the count, first trigger word stops it
	slm_latency u_latency (
		.sys_clk    (sys_clk),
		.resetn     (resetn),
		.sync_start (sync_start),
		.trig_word  (trig_word),
		.latency    (latency)
	);

	// ------------------------------------------------------------
	// debug registers
	// ------------------------------------------------------------
	// write strobes per offset; status and capture offsets take no write
	assign write_mask      = reg_wr && hit(reg_addr, slm_pkg::OFF_MASK);
	assign write_value     = reg_wr && hit(reg_addr, slm_pkg::OFF_VALUE);
	assign write_threshold = reg_wr && hit(reg_addr, slm_pkg::OFF_THRESHOLD);

	// match mask handed to the capture engine
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			debug_match_mask <= slm_pkg::RESET_WORD;
		end else if (write_mask) begin
			debug_match_mask <= reg_wdata;
		end
	end

	// match value handed to the capture engine
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			debug_match_value <= slm_pkg::RESET_WORD;
		end else if (write_value) begin
			debug_match_value <= reg_wdata;
		end
	end

	// trigger threshold handed to the capture engine
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			debug_threshold <= slm_pkg::RESET_WORD;
		end else if (write_threshold) begin
			debug_threshold <= reg_wdata;
		end
	end

	// ------------------------------------------------------------
	// capture readout
	// ------------------------------------------------------------
	// each read of the capture offset advances the capture store
	assign capture_word_pop = reg_rd && hit(reg_addr, slm_pkg::OFF_CAPTURE);

	// ------------------------------------------------------------
	// status word
	// ------------------------------------------------------------
	// fields placed by position so the reserved gaps always read zero
	always_comb begin
		status_value = 32'h0000_0000;
		status_value[slm_pkg::STS_DONE_BIT] = done_flag;
		status_value[slm_pkg::STS_LANE_MSB:slm_pkg::STS_LANE_LSB] = lane_check_pass;
		status_value[slm_pkg::STS_LAT_MSB:slm_pkg::STS_LAT_LSB] = latency;
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (reg_addr)
			slm_pkg::OFF_TAG: begin
				next_rdata[slm_pkg::TAG_WIDTH-1:0] = source_crate_tag;
			end
			slm_pkg::OFF_STATUS:    next_rdata = status_value;
			slm_pkg::OFF_MASK:      next_rdata = debug_match_mask;
			slm_pkg::OFF_VALUE:     next_rdata = debug_match_value;
			slm_pkg::OFF_THRESHOLD: next_rdata = debug_threshold;
			slm_pkg::OFF_CAPTURE:   next_rdata = capture_word;
			default:                next_rdata = 32'h0000_0000;
		endcase
	end

	// answer strobe one cycle after the read strobe
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
		end
	end

	// read data registered and held until the next read
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

endmodule

// [testbench/slm_properties.sv]
// concurrent checks on the link monitor ports
`timescale 1ns/1ps

module slm_properties (
	input wire logic                sys_clk,
	input wire logic                resetn,
	input wire logic [7:0]          reg_addr,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [31:0]         reg_wdata,
	input wire logic [31:0]         reg_rdata,
	input wire slm_pkg::slm_link_t  link_in,
	input wire slm_pkg::slm_check_t lane_check,
	input wire logic                sys_sync,
	input wire logic                trig_word,
	input wire logic                capture_done,
	input wire logic [15:0]         source_crate_tag
);
	logic       prev_valid;
	logic [3:0] last_pass;
	// reference copies of the link state and the last lane report
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prev_valid <= 1'b0;
			last_pass  <= 4'h0;
		end else begin
			prev_valid <= link_in.valid;
			if (lane_check.strobe)
				last_pass <= lane_check.pass;
		end
	end
	// capture beats clear, so the clear check skips link edges
	wire logic edge_in = link_in.valid && !prev_valid;
	wire logic clr     = reg_wr && reg_addr == 8'h30 && reg_wdata[0];
	wire logic st_rd   = reg_rd && reg_addr == 8'h34;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_sync_trig;
		$rose(sys_sync) ##1 !trig_word [*3] ##1 trig_word;
	endsequence
	AST_TAG_CLEAR: assert property (clr && !edge_in |=> source_crate_tag == 16'h0)
		else $error("tag not cleared");
	AST_TAG_CAPTURE: assert property (edge_in |=> source_crate_tag == $past(link_in.data[15:0]))
		else $error("tag not captured");
	AST_TAG_HOLD: assert property (!edge_in && !clr |=> $stable(source_crate_tag))
		else $error("tag changed mid frame");
	AST_DONE: assert property (st_rd |=> reg_rdata[0] == $past(capture_done, 2))
		else $error("done bit wrong");
	AST_LANE: assert property (st_rd |=> reg_rdata[11:8] == $past(last_pass))
		else $error("lane bits wrong");
	AST_LAT: assert property (s_sync_trig ##2 st_rd |=> reg_rdata[31:16] == 16'h3)
		else $error("latency wrong");
	AST_RSVD: assert property (st_rd |=> reg_rdata[15:12] == 4'h0 && reg_rdata[7:1] == 7'h0)
		else $error("reserved bits set");
endmodule

bind slm_link_monitor slm_properties i_props (.sys_clk, .resetn, .reg_addr, .reg_wr, .reg_rd,
	.reg_wdata, .reg_rdata, .link_in, .lane_check, .sys_sync, .trig_word, .capture_done,
	.source_crate_tag);

// [testbench/slm_far_model.sv]
// far-end trigger processor model driving the lane link word stream
`timescale 1ns/1ps

module slm_far_model (
	input  wire logic          sys_clk,
	input  wire logic          resetn,
	input  wire logic          send,
	input  wire logic [15:0]   tag,
	output slm_pkg::slm_link_t link_out
);
	// tag word leads each frame; filler and idle words keep toggling so
	// stale data never looks steady to the monitor
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			link_out <= '0;
		else if (send && !link_out.valid)
			link_out <= {1'b1, 16'h5a5a, tag};
		else
			link_out <= {send, ~link_out.data};
	end
endmodule

// [testbench/serial_lane_link_monitor_test.sv]
// self-checking bench for the link monitor register port
`timescale 1ns/1ps

module serial_lane_link_monitor_test;
	logic                sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
	logic                sys_sync = 0, trig_word = 0, capture_done = 0, send = 0;
	logic [7:0]          reg_addr = '0;
	logic [15:0]         tag = '0, crate_tag;
	logic [31:0]         reg_wdata = '0, reg_rdata, mask, mval, thr, cap_word = '0;
	logic                reg_rvalid, pop;
	slm_pkg::slm_link_t  link_in;
	slm_pkg::slm_check_t lane_check = '0;
	int                  miscompares = 0, checks_done = 0, pops = 0;
	logic [7:0]          offs [8] = '{8'h20, 8'h30, 8'h34, 8'h40, 8'h60, 8'h80, 8'h90, 8'hf0};

	slm_link_monitor i_dut (.sys_clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .reg_rvalid, .link_in, .lane_check, .sys_sync, .trig_word, .capture_done,
		.capture_word(cap_word), .debug_match_mask(mask), .debug_match_value(mval),
		.debug_threshold(thr), .capture_word_pop(pop), .source_crate_tag(crate_tag));
	slm_far_model i_far (.sys_clk, .resetn, .send, .tag, .link_out(link_in));

	// counts capture pops as the design raises them
	always @(posedge sys_clk)
		if (pop === 1'b1)
			pops++;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 0;
	endtask
	// read answers one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd   <= 1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 0;
		#1 chk("rvalid", 32'h1, {31'h0, reg_rvalid});
		chk("rdata", e, reg_rdata);
	endtask
	// one frame: tag word first, then three filler words
	task automatic frame(input logic [15:0] t);
		@(posedge sys_clk);
		send <= 1;
		tag  <= t;
		repeat (4) @(posedge sys_clk);
		send <= 0;
	endtask
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial forever #25 sys_clk = ~sys_clk;
	// whole run is under a hundred cycles
	initial begin
		#100000;
		miscompares++;
		wrap_up();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1;
		foreach (offs[i]) rd(offs[i], 32'h0);
		wr(8'h40, 32'h1234_5678);
		wr(8'h34, 32'hffff_ffff);
		rd(8'h40, 32'h1234_5678);
		rd(8'h34, 32'h0);
		chk("mask", 32'h1234_5678, mask);
		wr(8'h60, 32'hcafe_0001);
		wr(8'h80, 32'h0000_00ff);
		cap_word <= 32'h5555_aaaa;
		rd(8'h60, 32'hcafe_0001);
		rd(8'h80, 32'h0000_00ff);
		chk("value", 32'hcafe_0001, mval);
		chk("threshold", 32'h0000_00ff, thr);
		rd(8'h90, 32'h5555_aaaa);
		chk("pops", 32'h2, pops);
		$display("register test done");
		frame(16'h1234);
		rd(8'h20, 32'h1234);
		wr(8'h30, 32'h0);
		rd(8'h20, 32'h1234);
		wr(8'h30, 32'h1);
		rd(8'h20, 32'h0);
		rd(8'h30, 32'h0);
		frame(16'hbeef);
		rd(8'h20, 32'hbeef);
		chk("tag", 32'hbeef, {16'h0, crate_tag});
		$display("tag test done");
		@(posedge sys_clk);
		lane_check   <= {1'b1, 4'ha};
		capture_done <= 1;
		sys_sync     <= 1;
		@(posedge sys_clk);
		lane_check <= '0;
		repeat (3) @(posedge sys_clk);
		trig_word <= 1;
		@(posedge sys_clk);
		trig_word <= 0;
		rd(8'h34, 32'h0003_0a01);
		@(posedge sys_clk);
		trig_word <= 1;
		@(posedge sys_clk);
		trig_word <= 0;
		rd(8'h34, 32'h0003_0a01);
		$display("status test done");
		wrap_up();
	end
endmodule
